// File: inc/flash_cmd_consts.svh
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// Opcodes
`define OP_NOP 8'h00
`define OP_RESET_ARM 8'h66
`define OP_RESET_FIRE 8'h99
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_STD_ID 8'h9f
`define OP_SIGNATURE 8'hab
`define OP_MAKER_DEV_ID 8'h90
`define OP_PAGE_WRITE 8'h02
`define OP_QUAD_PAGE_WRITE 8'h38
`define OP_SECTOR_WIPE 8'h20
`define OP_HALF_BLOCK_WIPE 8'h52
`define OP_BLOCK_WIPE 8'hd8
`define OP_CHIP_WIPE 8'hc7
`define OP_STATUS_WRITE 8'h01
`define OP_SECURITY_WRITE 8'h2f
`define OP_PROTECT_SEL_WRITE 8'h68
`define OP_DEEP_POWERDOWN 8'hb9

// Identity values (arbitrary neutral values)
`define ID_MAKER 8'h5a
`define ID_TYPE 8'h11
`define ID_DENSITY 8'h22
`define ID_DEVICE 8'h33
`define ID_SIGNATURE 8'h33

// Maker/device ID read: dummy plus address bytes after the opcode
`define MDID_ADDR_BYTE 3'd3

// Wake delays in ns and cycles at 20 ns
`define CLK_PERIOD_NS 20
`define WAKE_ONE_NS 30000
`define WAKE_TWO_NS 30000
`define WAKE_ONE_CYC ((`WAKE_ONE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_TWO_CYC ((`WAKE_TWO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: inc/flash_cmd_pkg.sv
`default_nettype none
package flash_cmd_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR = 3'b001,
    ST_SHIFT_OUT = 3'b010,
    ST_IGNORE = 3'b011
  } frame_e;

  typedef enum logic [1:0] {
    PW_STANDBY = 2'b00,
    PW_DEEP = 2'b01,
    PW_WAKING = 2'b10
  } power_e;

  typedef struct packed {
    logic latch_cleared_by_cycle;
    logic wipe_or_write_start;
    logic mem_reset;
  } cmd_event_s;
endpackage
`default_nettype wire

// File: hdl/id_rom.sv
`default_nettype none
`include "flash_cmd_consts.svh"
module id_rom (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [1:0] sel,
  output logic [7:0] rd_data
);
  wire [7:0] rom_word;
  assign rom_word = (sel == 2'd0) ? `ID_MAKER :
                    (sel == 2'd1) ? `ID_TYPE :
                    (sel == 2'd2) ? `ID_DENSITY : `ID_DEVICE;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) rd_data <= 8'h00;
    else rd_data <= rom_word;
  end
endmodule // id_rom
`default_nettype wire

// File: hdl/flash_cmd_decoder.sv
// Functional notes
// - Reset fires only right after reset arm
// - Other opcode between arm and fire cancels
// - Latch set opcode sets write latch flag
// - Eight clocks single, two clocks quad
// - Latch clear opcode clears write latch flag
// - Listed events clear write latch flag
// - Standard id read shifts 24 bits
// - Standard id read ignored while busy
// - Release waits first delay if deep
// - Reset pin low exits deep powerdown
// - Signature byte repeats while selected
// - Signature in deep waits second delay
// - Release/signature accepted in deep unless busy
// - Maker/device id after dummies, msb first
// - Address picks maker or device first
// - Maker/device codes alternate while selected
// - Writes ignored while latch flag clear
`default_nettype none
`include "flash_cmd_consts.svh"
module flash_cmd_decoder
  import flash_cmd_pkg::*;
#(
  parameter int WAKE_ONE_CYCLES = `WAKE_ONE_CYC,
  parameter int WAKE_TWO_CYCLES = `WAKE_TWO_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chip_sel_n,
  input wire logic sclk,
  input wire logic [3:0] data_in,
  input wire logic quad_command_mode,
  input wire logic hw_reset_n,
  input wire logic busy,
  input wire logic suspend,
  input wire logic op_done,
  output logic [3:0] data_out,
  output logic [3:0] data_oe,
  output logic write_latch_flag,
  output logic deep_powerdown,
  output logic standby,
  output logic mem_reset,
  output logic write_start,
  output logic [7:0] write_opcode
);
  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic cs_s1_q, cs_s2_q;
  logic ck_s1_q, ck_s2_q;
  logic [3:0] din_s1_q, din_s2_q;
  logic rst_s1_q, rst_s2_q;
  logic ck_prev_q, cs_prev_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      din_s1_q <= 4'h0;
      din_s2_q <= 4'h0;
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
      ck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      cs_s1_q <= chip_sel_n;
      cs_s2_q <= cs_s1_q;
      ck_s1_q <= sclk;
      ck_s2_q <= ck_s1_q;
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
      rst_s1_q <= hw_reset_n;
      rst_s2_q <= rst_s1_q;
      ck_prev_q <= ck_s2_q;
      cs_prev_q <= cs_s2_q;
    end
  end

  wire cs_low = ~cs_s2_q;
  wire ck_rise = ck_s2_q & ~ck_prev_q & cs_low;
  wire ck_fall = ~ck_s2_q & ck_prev_q & cs_low;
  wire cs_rise = cs_s2_q & ~cs_prev_q;
  wire pin_reset = ~rst_s2_q;

  //////////////////////////////////////////////////////////////////////////
  // Opcode and address shifting
  frame_e frame_q, frame_d;
  logic [7:0] shift_q, opcode_q;
  logic [2:0] bit_cnt_q;
  logic [2:0] byte_cnt_q;
  logic [7:0] addr_q;
  logic quad_q;

  function automatic logic [7:0] shift_in(input logic [7:0] cur,
                                          input logic [3:0] lines,
                                          input logic quad);
    if (quad) shift_in = {cur[3:0], lines};
    else shift_in = {cur[6:0], lines[0]};
  endfunction

  // Upper lines are ignored in single-line mode
  wire [7:0] shift_nx = shift_in(shift_q, din_s2_q, quad_q);
  wire [2:0] last_bit = quad_q ? 3'd1 : 3'd7;
  wire byte_done = ck_rise & (bit_cnt_q == last_bit);

  wire is_write_op = (shift_nx == `OP_PAGE_WRITE) ||
                     (shift_nx == `OP_QUAD_PAGE_WRITE) ||
                     (shift_nx == `OP_SECTOR_WIPE) ||
                     (shift_nx == `OP_HALF_BLOCK_WIPE) ||
                     (shift_nx == `OP_BLOCK_WIPE) ||
                     (shift_nx == `OP_CHIP_WIPE) ||
                     (shift_nx == `OP_STATUS_WRITE) ||
                     (shift_nx == `OP_SECURITY_WRITE) ||
                     (shift_nx == `OP_PROTECT_SEL_WRITE);

  power_e power_q, power_d;
  wire in_deep = (power_q == PW_DEEP);
  // Deep state only lets the signature opcode through, and never when busy
  wire wake_op = (shift_nx == `OP_SIGNATURE);
  wire op_ok = in_deep ? (wake_op & ~busy) : 1'b1;
  wire op_take = byte_done & (frame_q == ST_OPCODE) & op_ok;

  wire take_std_id = op_take & (shift_nx == `OP_STD_ID) & ~busy &
                     ~quad_q;
  wire take_sig = op_take & (shift_nx == `OP_SIGNATURE);
  wire take_mdid = op_take & (shift_nx == `OP_MAKER_DEV_ID) & ~quad_q;
  wire take_write = op_take & is_write_op & write_latch_flag;

  always_comb begin
    frame_d = frame_q;
    case (frame_q)
      ST_OPCODE: begin
        if (byte_done) begin
          if (take_std_id | take_sig) frame_d = ST_SHIFT_OUT;
          else if (take_mdid) frame_d = ST_ADDR;
          else frame_d = ST_IGNORE;
        end
      end
      ST_ADDR: begin
        if (byte_done && byte_cnt_q == `MDID_ADDR_BYTE - 3'd1)
          frame_d = ST_SHIFT_OUT;
      end
      ST_SHIFT_OUT: frame_d = ST_SHIFT_OUT;
      ST_IGNORE: frame_d = ST_IGNORE;
      default: frame_d = ST_IGNORE;
    endcase
    if (!cs_low) frame_d = ST_OPCODE;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      frame_q <= ST_OPCODE;
      shift_q <= 8'h00;
      bit_cnt_q <= 3'd0;
      byte_cnt_q <= 3'd0;
      addr_q <= 8'h00;
      opcode_q <= 8'h00;
      quad_q <= 1'b0;
    end else begin
      frame_q <= frame_d;
      if (!cs_low) begin
        bit_cnt_q <= 3'd0;
        byte_cnt_q <= 3'd0;
        quad_q <= quad_command_mode;
      end else if (ck_rise) begin
        shift_q <= shift_nx;
        bit_cnt_q <= byte_done ? 3'd0 : bit_cnt_q + 3'd1;
        if (byte_done && frame_q == ST_ADDR) begin
          byte_cnt_q <= byte_cnt_q + 3'd1;
          addr_q <= shift_nx;
        end
        if (byte_done && frame_q == ST_OPCODE) opcode_q <= shift_nx;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset pairing and write latch
  logic armed_q;
  wire op_arm = op_take & (shift_nx == `OP_RESET_ARM);
  wire op_fire = op_take & (shift_nx == `OP_RESET_FIRE);
  // Any completed opcode other than the arm cancels the pending arm
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) armed_q <= 1'b0;
    else if (op_arm) armed_q <= 1'b1;
    else if (op_take) armed_q <= 1'b0;
  end
  wire fire_ok = op_fire & armed_q;

  // Latch set, latch clear and reset fire act on chip select rising after exactly one byte
  logic pend_set_q, pend_clr_q, pend_fire_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend_set_q <= 1'b0;
      pend_clr_q <= 1'b0;
      pend_fire_q <= 1'b0;
    end else if (!cs_low) begin
      pend_set_q <= 1'b0;
      pend_clr_q <= 1'b0;
      pend_fire_q <= 1'b0;
    end else if (op_take) begin
      pend_set_q <= (shift_nx == `OP_LATCH_SET);
      pend_clr_q <= (shift_nx == `OP_LATCH_CLEAR);
      pend_fire_q <= fire_ok;
    end else if (ck_rise) begin
      pend_set_q <= 1'b0;
      pend_clr_q <= 1'b0;
      pend_fire_q <= 1'b0;
    end
  end

  wire do_set = cs_rise & pend_set_q;
  wire do_fire = cs_rise & pend_fire_q;
  wire latch_clr = (cs_rise & pend_clr_q) | do_fire | pin_reset |
                   suspend | op_done;
  logic wlf_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) wlf_q <= 1'b0;
    else if (latch_clr) wlf_q <= 1'b0;
    else if (do_set) wlf_q <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Deep powerdown and wake delays
  logic [31:0] wake_cnt_q;
  wire op_dp = op_take & (shift_nx == `OP_DEEP_POWERDOWN) & ~busy;
  logic pend_dp_q, pend_wake_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend_dp_q <= 1'b0;
      pend_wake_q <= 1'b0;
    end else if (!cs_low) begin
      pend_dp_q <= 1'b0;
      pend_wake_q <= 1'b0;
    end else if (op_take) begin
      pend_dp_q <= op_dp;
      pend_wake_q <= in_deep & wake_op;
    end
  end
  // Release without readout uses the first delay, a readout the second
  // The trailing clock after the opcode alone does not count as a readout
  logic sig_seen_q;
  wire wake_sig = (frame_q == ST_SHIFT_OUT) & sig_seen_q;
  always_comb begin
    power_d = power_q;
    case (power_q)
      PW_STANDBY: if (cs_rise && pend_dp_q) power_d = PW_DEEP;
      PW_DEEP: if (cs_rise && pend_wake_q) power_d = PW_WAKING;
      PW_WAKING: if (wake_cnt_q == 32'd0) power_d = PW_STANDBY;
      default: power_d = PW_STANDBY;
    endcase
    if (pin_reset) power_d = PW_STANDBY;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      power_q <= PW_STANDBY;
      wake_cnt_q <= 32'd0;
    end else begin
      power_q <= power_d;
      if (power_q == PW_DEEP && power_d == PW_WAKING)
        wake_cnt_q <= wake_sig ? 32'(WAKE_TWO_CYCLES - 1)
                               : 32'(WAKE_ONE_CYCLES - 1);
      else if (wake_cnt_q != 32'd0)
        wake_cnt_q <= wake_cnt_q - 32'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Identification output
  logic [4:0] out_bit_q;
  logic [1:0] rom_sel_q;
  logic [7:0] out_byte_q;
  logic out_active_q;
  wire [7:0] rom_data;
  id_rom u_id_rom (
    .core_clk(core_clk),
    .reset(reset),
    .sel(rom_sel_q),
    .rd_data(rom_data)
  );
  wire [2:0] out_pos = 3'(out_bit_q);
  wire maker_first = (addr_q[0] == 1'b0);
  wire out_cmd_std = (opcode_q == `OP_STD_ID);
  wire out_cmd_mdid = (opcode_q == `OP_MAKER_DEV_ID);
  // Byte index inside the repeating pattern
  wire [1:0] byte_idx = 2'(out_bit_q >> 3);
  wire mdid_dev = byte_idx[0] ^ ~maker_first;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_bit_q <= 5'd0;
      rom_sel_q <= 2'd0;
      out_active_q <= 1'b0;
      sig_seen_q <= 1'b0;
    end else if (frame_q != ST_SHIFT_OUT) begin
      out_bit_q <= 5'd0;
      out_active_q <= 1'b0;
      sig_seen_q <= 1'b0;
      rom_sel_q <= (take_sig | (frame_q == ST_ADDR & ~maker_first)) ?
                   2'd3 : 2'd0;
    end else if (ck_fall) begin
      out_active_q <= 1'b1;
      sig_seen_q <= sig_seen_q | out_active_q;
      if (out_active_q)
        out_bit_q <= (out_cmd_std && out_bit_q == 5'd23) ? 5'd0 :
                     5'(out_bit_q + 5'd1);
    end else if (out_cmd_std) begin
      rom_sel_q <= byte_idx;
    end else if (out_cmd_mdid) begin
      rom_sel_q <= mdid_dev ? 2'd3 : 2'd0;
    end else begin
      rom_sel_q <= 2'd3;
    end
  end
  // Msb first, driven on the serial clock falling edge
  wire out_bit = rom_data[3'd7 - out_pos];

  //////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_out <= 4'h0;
      data_oe <= 4'h0;
      write_latch_flag <= 1'b0;
      deep_powerdown <= 1'b0;
      standby <= 1'b1;
      mem_reset <= 1'b0;
      write_start <= 1'b0;
      write_opcode <= 8'h00;
    end else begin
      // Id bits leave on the second data line, as in the wide modes
      data_out <= {2'b00, out_bit, 1'b0};
      data_oe <= {2'b00, (frame_q == ST_SHIFT_OUT) & out_active_q &
                  cs_low, 1'b0};
      write_latch_flag <= wlf_q;
      deep_powerdown <= (power_q == PW_DEEP);
      standby <= (power_q == PW_STANDBY);
      mem_reset <= do_fire;
      write_start <= take_write;
      if (take_write) write_opcode <= shift_nx;
    end
  end
endmodule // flash_cmd_decoder
`default_nettype wire

// File: bench/flash_host_model.sv
`default_nettype none
module flash_host_model (
  input wire logic core_clk,
  input wire logic [3:0] data_out,
  input wire logic [3:0] data_oe,
  output logic chip_sel_n,
  output logic sclk,
  output logic [3:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////////////////////////
  initial begin
    chip_sel_n = 1'b1;
    sclk = 1'b0;
    data_in = 4'h0;
  end
  // Half of the 160 ns link clock; sclk idles low between frames
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask
  task automatic open_frame();
    @(posedge core_clk);
    chip_sel_n <= 1'b0;
    half();
  endtask
  // Deselect time outlasts both wake delays; released lines toggle
  task automatic close_frame();
    half();
    chip_sel_n <= 1'b1;
    data_in <= ~data_in;
    repeat (20) @(posedge core_clk);
  endtask
  task automatic put(input logic [7:0] b, input logic quad);
    for (int i = 7; i >= 0; i -= (quad ? 4 : 1)) begin
      if (quad) begin
        data_in <= (i == 7) ? b[7:4] : b[3:0];
      end else begin
        data_in <= {~data_in[3:1], b[i]};
      end
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask
  // Bits are taken just before the falling edge that replaces them
  task automatic get(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      half();
      sclk <= 1'b1;
      half();
      // An undriven line reads inverted, so a missing enable shows up
      b[i] = data_oe[1] ? data_out[1] : ~data_out[1];
      sclk <= 1'b0;
    end
  endtask
endmodule // flash_host_model
`default_nettype wire

// File: bench/flash_cmd_decoder_chk.sv
`default_nettype none
module flash_cmd_decoder_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chip_sel_n,
  input wire logic hw_reset_n,
  input wire logic suspend,
  input wire logic op_done,
  input wire logic [3:0] data_oe,
  input wire logic write_latch_flag,
  input wire logic deep_powerdown,
  input wire logic standby,
  input wire logic mem_reset,
  input wire logic write_start
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////
  latch_rise_a: assert property ($rose(write_latch_flag) |->
    chip_sel_n && !deep_powerdown) else $error("latch set mid frame");
  reset_pulse_a: assert property (mem_reset |=> !mem_reset)
    else $error("memory reset pulse too long");
  reset_clears_a: assert property (mem_reset |->
    ##[0:2] !write_latch_flag) else $error("soft reset kept latch");
  start_gate_a: assert property (write_start |->
    $past(write_latch_flag)) else $error("write started without latch");
  done_clears_a: assert property (op_done |->
    ##[1:3] !write_latch_flag) else $error("completion kept latch");
  susp_clears_a: assert property (suspend |->
    ##[1:3] !write_latch_flag) else $error("suspend kept latch");
  pin_reset_a: assert property (!hw_reset_n [*4] |->
    ##[0:4] (!write_latch_flag && !deep_powerdown))
    else $error("reset pin ignored");
  deep_standby_a: assert property (deep_powerdown |-> !standby)
    else $error("standby while deep");
  idle_quiet_a: assert property (chip_sel_n [*8] |->
    data_oe == 4'h0) else $error("lines driven while deselected");
endmodule // flash_cmd_decoder_chk
bind flash_cmd_decoder flash_cmd_decoder_chk chk (
  .core_clk(core_clk), .reset(reset), .chip_sel_n(chip_sel_n),
  .hw_reset_n(hw_reset_n), .suspend(suspend), .op_done(op_done),
  .data_oe(data_oe), .write_latch_flag(write_latch_flag),
  .deep_powerdown(deep_powerdown), .standby(standby),
  .mem_reset(mem_reset), .write_start(write_start));
`default_nettype wire

// File: bench/serial_flash_latch_id_reset_cmds_bench.sv
`default_nettype none
`include "flash_cmd_consts.svh"
module serial_flash_latch_id_reset_cmds_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAKE_ONE = 4;
  localparam int WAKE_TWO = 8;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic quad_command_mode = 1'b0;
  logic hw_reset_n = 1'b1;
  logic busy = 1'b0;
  logic suspend = 1'b0;
  logic op_done = 1'b0;
  logic chip_sel_n, sclk, wl, deep, stby, mrst, wstart;
  logic [3:0] data_in, data_out, data_oe;
  logic [7:0] wop;
  int error_cnt = 0;
  int total_checks = 0;
  int rst_n = 0;
  int st_n = 0;
  int oe_n = 0;
  int wake_n = 0;
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (mrst === 1'b1) rst_n++;
    if (wstart === 1'b1) st_n++;
    if (data_oe[1] === 1'b1) oe_n++;
    if (stby === 1'b0 && deep === 1'b0) wake_n++;
  end
  flash_cmd_decoder #(
    .WAKE_ONE_CYCLES(WAKE_ONE),
    .WAKE_TWO_CYCLES(WAKE_TWO)
  ) uut (
    .core_clk(core_clk), .reset(reset), .chip_sel_n(chip_sel_n),
    .sclk(sclk), .data_in(data_in), .quad_command_mode(quad_command_mode),
    .hw_reset_n(hw_reset_n), .busy(busy), .suspend(suspend),
    .op_done(op_done), .data_out(data_out), .data_oe(data_oe),
    .write_latch_flag(wl), .deep_powerdown(deep), .standby(stby),
    .mem_reset(mrst), .write_start(wstart), .write_opcode(wop));
  flash_host_model host (.core_clk(core_clk), .data_out(data_out),
    .data_oe(data_oe), .chip_sel_n(chip_sel_n), .sclk(sclk),
    .data_in(data_in));
  //////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic flag(input string nm, input logic e, input logic g);
    cmp(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic cmd(input logic [7:0] op, input logic quad);
    host.open_frame();
    host.put(op, quad);
    host.close_frame();
  endtask
  task automatic pin_reset();
    hw_reset_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    hw_reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic latch_cmds();
    cmd(`OP_LATCH_SET, 1'b0);
    flag("set", 1'b1, wl);
    cmd(`OP_LATCH_CLEAR, 1'b0);
    flag("clear", 1'b0, wl);
    quad_command_mode <= 1'b1;
    cmd(`OP_LATCH_SET, 1'b1);
    flag("quad set", 1'b1, wl);
    cmd(`OP_NOP, 1'b1);
    flag("nop", 1'b1, wl);
    quad_command_mode <= 1'b0;
  endtask
  task automatic clear_events();
    op_done <= 1'b1;
    @(posedge core_clk);
    op_done <= 1'b0;
    repeat (4) @(posedge core_clk);
    flag("done", 1'b0, wl);
    cmd(`OP_LATCH_SET, 1'b0);
    suspend <= 1'b1;
    @(posedge core_clk);
    suspend <= 1'b0;
    repeat (4) @(posedge core_clk);
    flag("suspend", 1'b0, wl);
    cmd(`OP_LATCH_SET, 1'b0);
    pin_reset();
    flag("pin", 1'b0, wl);
    cmd(`OP_LATCH_SET, 1'b0);
    cmd(`OP_RESET_ARM, 1'b0);
    cmd(`OP_RESET_FIRE, 1'b0);
    cmp("fired", 8'h01, rst_n[7:0]);
    flag("soft", 1'b0, wl);
    cmd(`OP_RESET_ARM, 1'b0);
    cmd(`OP_LATCH_SET, 1'b0);
    cmd(`OP_RESET_FIRE, 1'b0);
    cmp("disarmed", 8'h01, rst_n[7:0]);
    flag("kept", 1'b1, wl);
  endtask
  task automatic write_gate();
    cmd(`OP_SECTOR_WIPE, 1'b0);
    cmp("start", 8'h01, st_n[7:0]);
    cmp("opcode", `OP_SECTOR_WIPE, wop);
    op_done <= 1'b1;
    @(posedge core_clk);
    op_done <= 1'b0;
    cmd(`OP_PAGE_WRITE, 1'b0);
    cmp("gated", 8'h01, st_n[7:0]);
  endtask
  task automatic id_reads();
    logic [7:0] b;
    logic [7:0] ids [3];
    ids = '{`ID_MAKER, `ID_TYPE, `ID_DENSITY};
    host.open_frame();
    host.put(`OP_STD_ID, 1'b0);
    for (int i = 0; i < 3; i++) begin
      host.get(b);
      cmp("std id", ids[i], b);
    end
    host.close_frame();
    for (int a = 0; a < 2; a++) begin
      host.open_frame();
      host.put(`OP_MAKER_DEV_ID, 1'b0);
      host.put(8'h00, 1'b0);
      host.put(8'h00, 1'b0);
      host.put(a[7:0], 1'b0);
      for (int k = 0; k < 3; k++) begin
        host.get(b);
        cmp("mdid", ((a + k) % 2) ? `ID_DEVICE : `ID_MAKER, b);
      end
      host.close_frame();
    end
    busy <= 1'b1;
    oe_n = 0;
    host.open_frame();
    host.put(`OP_STD_ID, 1'b0);
    host.get(b);
    host.close_frame();
    busy <= 1'b0;
    cmp("busy oe", 8'h00, oe_n[7:0]);
  endtask
  task automatic deep_cycle();
    logic [7:0] b;
    cmd(`OP_DEEP_POWERDOWN, 1'b0);
    flag("deep", 1'b1, deep);
    cmd(`OP_LATCH_SET, 1'b0);
    flag("deep latch", 1'b0, wl);
    wake_n = 0;
    cmd(`OP_SIGNATURE, 1'b0);
    flag("released", 1'b1, stby);
    cmp("release wake", 8'(WAKE_ONE), wake_n[7:0]);
    cmd(`OP_DEEP_POWERDOWN, 1'b0);
    wake_n = 0;
    host.open_frame();
    host.put(`OP_SIGNATURE, 1'b0);
    host.get(b);
    cmp("sig", `ID_SIGNATURE, b);
    host.get(b);
    cmp("sig again", `ID_SIGNATURE, b);
    host.close_frame();
    flag("sig wake", 1'b1, stby);
    cmp("sig wake time", 8'(WAKE_TWO), wake_n[7:0]);
    cmd(`OP_DEEP_POWERDOWN, 1'b0);
    busy <= 1'b1;
    cmd(`OP_SIGNATURE, 1'b0);
    flag("busy deep", 1'b1, deep);
    busy <= 1'b0;
    pin_reset();
    flag("pin wake", 1'b0, deep);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    repeat (8) @(posedge core_clk);
    latch_cmds();
    clear_events();
    write_gate();
    id_reads();
    deep_cycle();
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule // serial_flash_latch_id_reset_cmds_bench
`default_nettype wire
